/* core/card_dcdc_b_config_reg.sv */
// Behaviour
// R01 - Voltage-good flag set only while output sits inside the selected range.
// R02 - Host should wait for voltage-good before activating a matching card.
// R03 - Host writes zero to bit 4; device treats it as reserved.
// R04 - Sensitivity adjust bit raises overcurrent threshold by about 20 percent.
// R05 - Select 01 gives 2.2V, 10 gives 3.2V, 11 gives 5.2V.
// R06 - Changing voltage select never starts a card deactivation.
// R07 - Host keeps selected voltage above every active card's need.
// R08 - Host may lower the select after higher-class cards are deactivated.
// R09 - Select kept on card deactivation; only host clears it to stop.
// R10 - Interrupt flag set on supply-good change, cleared by host read.
// R11 - Shutdown bit stops converter and triggers automatic card deactivation.
// R12 - Step regulator disable bit turns automatic stepping off.
`include "converter_defines.svh"
`default_nettype none

module card_dcdc_b_config_reg
  import converter_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_output_in_range,
  input wire logic i_card_supply_good,
  output logic [7:0] o_reg_rdata,
  output logic o_converter_enable,
  output logic o_deactivate_req,
  output logic o_overcurrent_raise,
  output logic o_step_regulator_disable,
  output logic [1:0] o_voltage_level,
  output logic o_converter_voltage_good,
  output logic o_converter_supply_irq_flag
);

  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Reset release
  // ****************************************
  // Release leaves on a clock edge so no flop sees a runt release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************
  // Analog status inputs
  // ****************************************
  // Both levels come from the analog side, asynchronous to the clock
  logic [1:0] status_sync;

  sync_2ff #(.WIDTH(2)) status_sync_inst (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n_reg),
    .i_async({i_card_supply_good, i_output_in_range}),
    .o_sync(status_sync)
  );

  logic in_range_sync;
  logic supply_good_sync;

  assign in_range_sync = status_sync[0];
  assign supply_good_sync = status_sync[1];

  // ****************************************
  // Host-written control fields
  // ****************************************
  logic converter_off_ctrl_reg;
  logic converter_off_ctrl_next;
  logic overcurrent_sensitivity_adjust_reg;
  logic overcurrent_sensitivity_adjust_next;
  logic step_regulator_disable_reg;
  logic step_regulator_disable_next;
  voltage_select_t converter_voltage_select_reg;
  voltage_select_t converter_voltage_select_next;

  always_comb begin
    converter_off_ctrl_next = converter_off_ctrl_reg;
    overcurrent_sensitivity_adjust_next = overcurrent_sensitivity_adjust_reg;
    step_regulator_disable_next = step_regulator_disable_reg;
    // Select only ever changes on a host write, never on deactivation
    converter_voltage_select_next = converter_voltage_select_reg; // R09
    if (i_reg_wr) begin
      // Status bits and the reserved bit ignore writes
      converter_off_ctrl_next = i_reg_wdata[`CONV_OFF_BIT]; // R11
      overcurrent_sensitivity_adjust_next = i_reg_wdata[`CONV_OCADJ_BIT]; // R04
      step_regulator_disable_next = i_reg_wdata[`CONV_STEPDIS_BIT]; // R12
      converter_voltage_select_next = voltage_select_t'(i_reg_wdata[`CONV_VSEL_HI:`CONV_VSEL_LO]); // R05
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      converter_off_ctrl_reg <= 1'b0;
      overcurrent_sensitivity_adjust_reg <= 1'b0;
      step_regulator_disable_reg <= 1'b0;
      converter_voltage_select_reg <= voltage_select_t'(`CONV_VSEL_RESET);
    end else begin
      converter_off_ctrl_reg <= converter_off_ctrl_next;
      overcurrent_sensitivity_adjust_reg <= overcurrent_sensitivity_adjust_next;
      step_regulator_disable_reg <= step_regulator_disable_next;
      converter_voltage_select_reg <= converter_voltage_select_next;
    end
  end

  // ****************************************
  // Converter run control
  // ****************************************
  logic enable_reg;
  logic enable_next;
  logic deactivate_req_reg;
  logic deactivate_req_next;

  always_comb begin
    // Converter stops for shutdown or for a cleared select
    enable_next = !converter_off_ctrl_next && (converter_voltage_select_next != vsel_off); // R11
    // Only the shutdown bit going high starts deactivation; select changes do not
    deactivate_req_next = converter_off_ctrl_next && !converter_off_ctrl_reg; // R06 R11
  end

  always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      enable_reg <= 1'b0;
      deactivate_req_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      deactivate_req_reg <= deactivate_req_next;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic converter_voltage_good_reg;
  logic converter_voltage_good_next;
  logic supply_good_last_reg;
  logic supply_good_last_next;
  logic converter_supply_irq_flag_reg;
  logic converter_supply_irq_flag_next;

  always_comb begin
    // Good needs a running converter and the comparator inside its window
    converter_voltage_good_next = enable_reg && in_range_sync; // R01
    // An edge in the same cycle as the read wins, so no event is lost
    supply_good_last_next = supply_good_sync;
    converter_supply_irq_flag_next = converter_supply_irq_flag_reg;
    if (i_reg_rd) begin
      converter_supply_irq_flag_next = 1'b0; // R10
    end
    if (supply_good_sync != supply_good_last_reg) begin
      converter_supply_irq_flag_next = 1'b1; // R10
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      converter_voltage_good_reg <= 1'b0;
      supply_good_last_reg <= 1'b0;
      converter_supply_irq_flag_reg <= 1'b0;
    end else begin
      converter_voltage_good_reg <= converter_voltage_good_next;
      supply_good_last_reg <= supply_good_last_next;
      converter_supply_irq_flag_reg <= converter_supply_irq_flag_next;
    end
  end

  // ****************************************
  // Register image and read data
  // ****************************************
  logic [7:0] reg_view;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    reg_view = `CONV_RESET_VALUE;
    reg_view[`CONV_OFF_BIT] = converter_off_ctrl_reg;
    reg_view[`CONV_IRQ_BIT] = converter_supply_irq_flag_reg;
    reg_view[`CONV_GOOD_BIT] = converter_voltage_good_reg;
    reg_view[`CONV_RSVD_BIT] = 1'b0; // R03
    reg_view[`CONV_OCADJ_BIT] = overcurrent_sensitivity_adjust_reg;
    reg_view[`CONV_STEPDIS_BIT] = step_regulator_disable_reg;
    reg_view[`CONV_VSEL_HI:`CONV_VSEL_LO] = converter_voltage_select_reg;
  end

  always_comb begin
    // Byte is frozen at the read edge so a slow host sees a stable value
    rdata_next = rdata_reg;
    if (i_reg_rd) begin
      rdata_next = reg_view;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= `CONV_RESET_VALUE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a flop, so the analog side never sees decode glitches
  assign o_reg_rdata = rdata_reg;
  assign o_converter_enable = enable_reg;
  assign o_deactivate_req = deactivate_req_reg;
  assign o_overcurrent_raise = overcurrent_sensitivity_adjust_reg; // R04
  assign o_step_regulator_disable = step_regulator_disable_reg;
  assign o_voltage_level = converter_voltage_select_reg;
  assign o_converter_voltage_good = converter_voltage_good_reg;
  assign o_converter_supply_irq_flag = converter_supply_irq_flag_reg;

endmodule

`default_nettype wire

/* core/converter_defines.svh */
`ifndef CONVERTER_DEFINES_SVH
`define CONVERTER_DEFINES_SVH

// ****************************************
// Field positions of the converter register
// ****************************************
`define CONV_OFF_BIT 7
`define CONV_IRQ_BIT 6
`define CONV_GOOD_BIT 5
`define CONV_RSVD_BIT 4
`define CONV_OCADJ_BIT 3
`define CONV_STEPDIS_BIT 2
`define CONV_VSEL_HI 1
`define CONV_VSEL_LO 0

// ****************************************
// Reset values
// ****************************************
`define CONV_RESET_VALUE 8'h00
`define CONV_VSEL_RESET 2'h0

`endif

/* core/converter_pkg.sv */
`default_nettype none

package converter_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // Encodings follow declaration order: off, 2.2 V, 3.2 V, 5.2 V
  typedef enum logic [1:0] {
    vsel_off,
    vsel_2v2_class_c,
    vsel_3v2_class_bc,
    vsel_5v2_class_abc
  } voltage_select_t;

endpackage

`default_nettype wire

/* core/sync_2ff.sv */
`default_nettype none

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  timeunit 1ns;
  timeprecision 1ps;

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* dv/card_dcdc_b_config_reg_tb.sv */
`default_nettype none
module card_dcdc_b_config_reg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 0, i_reset_n = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic i_output_in_range = 0, i_card_supply_good = 0;
  logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
  logic o_converter_enable, o_deactivate_req, o_overcurrent_raise, o_step_regulator_disable;
  logic [1:0] o_voltage_level;
  logic o_converter_voltage_good, o_converter_supply_irq_flag;
  int n_fail = 0, comparisons = 0;
  // ****
  // Status image: enable, pulse, adjust, step, level, good, flag
  // ****
  wire logic [7:0] st = {o_converter_enable, o_deactivate_req, o_overcurrent_raise,
    o_step_regulator_disable, o_voltage_level, o_converter_voltage_good, o_converter_supply_irq_flag};
  card_dcdc_b_config_reg u_dut (.*);
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_wr = 1;
    i_reg_wdata = d;
    @(negedge i_ref_clk);
    i_reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] exp);
    @(negedge i_ref_clk);
    i_reg_rd = 1;
    @(negedge i_ref_clk);
    i_reg_rd = 0;
    chk(o_reg_rdata, exp);
  endtask
  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Whole run is under a hundred cycles; this is far beyond it
  initial begin
    #20000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
  initial begin
    repeat (3) @(negedge i_ref_clk);
    i_reset_n = 1;
    repeat (3) @(negedge i_ref_clk);
    chk(st, 8'h00);
    rd(8'h00);
    $display("reset test done");
    // Bits 6..4 written as ones must not stick
    for (int i = 0; i < 4; i++) begin
      wr(8'h70 | 8'(i * 5));
      chk(st, {i != 0, 1'b0, 4'(i * 5), 2'b00});
      rd(8'(i * 5));
    end
    $display("select test done");
    wr(8'h83);
    chk(st, 8'h4C);
    @(negedge i_ref_clk);
    chk(st, 8'h0C);
    wr(8'h83);
    chk(st, 8'h0C);
    rd(8'h83);
    wr(8'h03);
    chk(st, 8'h8C);
    $display("shutdown test done");
    i_output_in_range = 1;
    repeat (4) @(negedge i_ref_clk);
    chk(st, 8'h8E);
    rd(8'h23);
    i_output_in_range = 0;
    repeat (4) @(negedge i_ref_clk);
    chk(st, 8'h8C);
    $display("good test done");
    i_card_supply_good = 1;
    repeat (4) @(negedge i_ref_clk);
    chk(st, 8'h8D);
    rd(8'h43);
    chk(st, 8'h8C);
    rd(8'h03);
    $display("flag test done");
    i_card_supply_good = 0;
    repeat (4) @(negedge i_ref_clk);
    chk(st, 8'h8D);
    rd(8'h43);
    $display("falling flag test done");
    wr(8'h02);
    chk(st, 8'h88);
    wr(8'h01);
    chk(st, 8'h84);
    wr(8'h00);
    chk(st, 8'h00);
    rd(8'h00);
    $display("lowering test done");
    wr(8'h0F);
    chk(st, 8'hBC);
    @(negedge i_ref_clk);
    i_reset_n = 0;
    repeat (3) @(negedge i_ref_clk);
    i_reset_n = 1;
    repeat (3) @(negedge i_ref_clk);
    chk(st, 8'h00);
    rd(8'h00);
    $display("second reset test done");
    conclude;
  end
endmodule
`default_nettype wire

/* dv/conv_reg_props.sv */
`default_nettype none
module conv_reg_props (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_output_in_range,
  input wire logic i_card_supply_good,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_converter_enable,
  input wire logic o_deactivate_req,
  input wire logic o_overcurrent_raise,
  input wire logic o_step_regulator_disable,
  input wire logic [1:0] o_voltage_level,
  input wire logic o_converter_voltage_good,
  input wire logic o_converter_supply_irq_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Checks
  // ****
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  AST_FIELDS: assert property (i_reg_wr |=> {o_overcurrent_raise, o_step_regulator_disable,
    o_voltage_level} == $past(i_reg_wdata[3:0])) else $error("fields");
  AST_EN: assert property (i_reg_wr |=> o_converter_enable ==
    (!$past(i_reg_wdata[7]) && $past(i_reg_wdata[1:0]) != 2'h0)) else $error("enable");
  AST_NODEACT: assert property (i_reg_wr && !i_reg_wdata[7] |=> !o_deactivate_req) else $error("deact");
  AST_DEACT_ONE: assert property (o_deactivate_req |=> !o_deactivate_req) else $error("pulse");
  AST_GOOD: assert property ($rose(o_converter_voltage_good) |-> $past(i_output_in_range, 3)) else $error("good");
  AST_IRQ: assert property ($changed(i_card_supply_good) |-> ##3 o_converter_supply_irq_flag) else $error("irq");
  AST_IRQ_CLR: assert property (i_reg_rd && $past(i_card_supply_good, 3) == $past(i_card_supply_good, 2)
    |=> !o_converter_supply_irq_flag) else $error("irq clear");
  AST_RD: assert property (i_reg_rd |=> o_reg_rdata[6:0] == $past({o_converter_supply_irq_flag,
    o_converter_voltage_good, 1'b0, o_overcurrent_raise, o_step_regulator_disable, o_voltage_level}))
    else $error("read");
  cover property (o_deactivate_req);
  cover property ($rose(o_converter_voltage_good));
  cover property (o_converter_supply_irq_flag ##1 !o_converter_supply_irq_flag);
endmodule
bind card_dcdc_b_config_reg conv_reg_props u_props (.*);
`default_nettype wire
